//--- ivp_cfg.svh
/*
 * Constants of the interrupt vector and priority controller: vector table
 * layout, register offsets, field positions and reset values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef IVP_CFG_SVH
`define IVP_CFG_SVH

// Vector table layout, word addresses in bytes.
`define IVP_TRAP_BASE 24'h000004
`define IVP_TRAP_LAST 24'h000012
`define IVP_IRQ_BASE 24'h000014
`define IVP_ALT_OFFSET 24'h000100
`define IVP_IRQ_VEC_OFFSET 7'h08
`define IVP_NUM_TRAPS 8
`define IVP_NUM_IRQ 118
`define IVP_LAST_LIVE_IRQ 71

// Source routing.
`define IVP_IRQ_I2CB_TGT 49
`define IVP_IRQ_I2CB_CTL 50
`define IVP_IRQ_EXT3 53
`define IVP_IRQ_EXT4 54
`define IVP_IRQ_CANB_RX 55
`define IVP_IRQ_CANB_EVT 56
`define IVP_IRQ_CODEC_ERR 59
`define IVP_IRQ_CODEC_DONE 60
`define IVP_IRQ_XFER5 61
`define IVP_IRQ_XFER6 68
`define IVP_IRQ_XFER7 69
`define IVP_IRQ_CANA_TX 70
`define IVP_IRQ_CANB_TX 71

// Flag status register 2 covers requests 32 to 47.
`define IVP_FS2_FIRST_IRQ 32
// Priority control register 3 fields: request numbers and bit positions.
`define IVP_PC3_UART_A_TX_IRQ 11
`define IVP_PC3_CONV_DONE_IRQ 12
`define IVP_PC3_XFER1_IRQ 13
`define IVP_PC3_UART_A_TX_LSB 0
`define IVP_PC3_CONV_DONE_LSB 4
`define IVP_PC3_XFER1_LSB 8

// Priority codes.
`define IVP_PRIO_RESET 3'h4
`define IVP_PRIO_OFF 3'h0
`define IVP_PRIO_TOP 3'h7

// Register byte offsets.
`define IVP_REG_CTRL 8'h00
`define IVP_REG_FLAG_STATUS_2 8'h04
`define IVP_REG_PRIO_CTRL_3 8'h08
`define IVP_REG_PRIO_SEL 8'h0c
`define IVP_REG_PRIO_DATA 8'h10
`define IVP_REG_STATUS 8'h14
`define IVP_CTRL_ALT_BIT 0

`define IVP_BLOCK_CNT_W 14

`endif

//--- ivp_pkg.sv
/*
 * Types shared by the interrupt vector and priority controller modules.
 * Assumes the constants header is on the include path.
 */
`include "ivp_cfg.svh"

package ivp_pkg;
   typedef logic [2:0] ivp_prio_t;
   typedef logic [23:0] ivp_vec_addr_t;
   typedef logic [6:0] ivp_irq_num_t;
   typedef logic [6:0] ivp_vec_num_t;
   typedef logic [`IVP_BLOCK_CNT_W-1:0] ivp_block_cnt_t;
   typedef enum logic [1:0] {IVP_DISP_NONE, IVP_DISP_TRAP, IVP_DISP_IRQ} ivp_disp_t;
endpackage

//--- ivp_prio_mem.sv
/*
 * Priority store: one 3-bit priority per request, all visible in parallel
 * for arbitration, plus one registered read port for software.
 * Assumes synchronous reset and a clock enable from the controller.
 */
`timescale 1ns/1ns
`include "ivp_cfg.svh"

module ivp_prio_mem #(
   parameter int DEPTH = `IVP_NUM_IRQ
) (
   input wire logic clk, // Instruction clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic ce, // Clock enable.
   input wire logic wrEn, // Write strobe.
   input wire logic [6:0] wrAddr, // Request number to write.
   input wire ivp_pkg::ivp_prio_t wrData, // New priority.
   input wire logic [6:0] rdAddr, // Request number to read.
   output ivp_pkg::ivp_prio_t rdData_q, // Registered read data.
   output logic [3*DEPTH-1:0] prioFlat // All priorities.
);
   import ivp_pkg::*;

   ivp_prio_t mem_q [DEPTH];
   ivp_prio_t mem_d [DEPTH];
   ivp_prio_t rdData_d;

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
         if (wrEn && (int'(wrAddr) == i)) begin
            mem_d[i] = wrData;
         end
         prioFlat[3*i +: 3] = mem_q[i];
      end
      rdData_d = (int'(rdAddr) < DEPTH) ? mem_q[rdAddr] : `IVP_PRIO_OFF;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= `IVP_PRIO_RESET;
         end
         rdData_q <= `IVP_PRIO_OFF;
      end else if (ce) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
         end
         rdData_q <= rdData_d;
      end
   end
endmodule // ivp_prio_mem

//--- ivp_ctrl.sv
/*
 * Interrupt and trap controller: latches requests as flags, weighs them by
 * priority and presents the winning vector address to the CPU core.
 * Assumes an AHB-Lite master on the register bus, one-cycle event pulses
 * from peripherals, and a CPU that pulses an acknowledge when it takes a vector.
 */
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
// Notes on behaviour
// - Trap vectors 0 to 7 sit at consecutive words from 0x000004 to 0x000012.
// - Traps 1 to 5 are oscillator, address, stack, math and transfer errors; 0, 6, 7 reserved.
// - The alternate table mirrors the primary one 0x100 bytes higher when selected.
// - Request n uses vector number n plus eight at address 0x000014 plus twice n.
// - The second I2C unit's target and controller events feed requests 49 and 50.
// - External pins 3 and 4 feed requests 53 and 54.
// - The second CAN unit's receive-ready and general events feed requests 55 and 56.
// - Codec interface error and transfer-done feed requests 59 and 60.
// - Transfer channels 5, 6 and 7 completion feed requests 61, 68 and 69.
// - The two CAN units' transmit-data requests feed requests 70 and 71.
// - Flag status register 2 holds CAN-A receive at bit 2, serial-B event at 1, error at 0.
// - A flag reads 1 once its source has requested and 0 while none has.
// - Priority register 3 holds three 3-bit fields, 7 highest, 0 off, reset to 4.
// - The temporary block instruction masks priorities below 7 for N instructions.
`timescale 1ns/1ns
`include "ivp_cfg.svh"

module ivp_ctrl #(
   parameter int NUM_IRQ = `IVP_NUM_IRQ
) (
   input wire logic clk, // Instruction clock, 10 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic hsel, // AHB slave select.
   input wire logic [31:0] haddr, // AHB address.
   input wire logic [1:0] htrans, // AHB transfer type.
   input wire logic hwrite, // AHB write.
   input wire logic [2:0] hsize, // AHB size.
   input wire logic [31:0] hwdata, // AHB write data.
   input wire logic hready, // AHB bus ready.
   output logic hreadyout_q, // AHB slave ready.
   output logic [31:0] hrdata_q, // AHB read data.
   output logic hresp_q, // AHB response, always OKAY.
   input wire logic [NUM_IRQ-1:0] irqEvent, // Generic request pulses.
   input wire logic [`IVP_NUM_TRAPS-1:0] trapEvent, // Trap pulses.
   input wire logic i2cBTargetEvent, // Second I2C target event.
   input wire logic i2cBControllerEvent, // Second I2C controller event.
   input wire logic extPinIrq3, // External pin 3 event.
   input wire logic extPinIrq4, // External pin 4 event.
   input wire logic canBRxReady, // CAN-B receive ready.
   input wire logic canBEvent, // CAN-B general event.
   input wire logic codecIfError, // Codec interface error.
   input wire logic codecIfDone, // Codec interface done.
   input wire logic xferChan5Done, // Transfer channel 5 done.
   input wire logic xferChan6Done, // Transfer channel 6 done.
   input wire logic xferChan7Done, // Transfer channel 7 done.
   input wire logic canATxRequest, // CAN-A transmit request.
   input wire logic canBTxRequest, // CAN-B transmit request.
   input wire ivp_pkg::ivp_prio_t cpuPriority, // Current CPU level.
   input wire logic blockStart, // Temporary block instruction executed.
   input wire ivp_pkg::ivp_block_cnt_t blockCount, // Its instruction count.
   input wire logic instrRetire, // One instruction completed.
   input wire logic cpuAck, // CPU takes the presented vector.
   output logic vecValid_q, // A vector is presented.
   output logic vecIsTrap_q, // Presented vector is a trap.
   output ivp_pkg::ivp_vec_num_t vecNum_q, // Vector number.
   output ivp_pkg::ivp_vec_addr_t vecAddr_q, // Vector word address.
   output logic blockActive_q // Temporary block in force.
);
   import ivp_pkg::*;

   function automatic logic slotLive(input int n);
      slotLive = (n <= `IVP_LAST_LIVE_IRQ) && (n != 57) && (n != 58) && (n != 62) &&
                 (n != 63) && (n != 64) && (n != 67);
   endfunction

   function automatic logic trapLive(input int n);
      // only traps 1 to 5 exist
      trapLive = (n >= 1) && (n <= 5);
   endfunction

   function automatic ivp_vec_addr_t vecAddr(input logic trap, input ivp_irq_num_t n,
                                             input logic alt);
      ivp_vec_addr_t a;
      // trap words from the trap base
      // request words from the request base
      a = trap ? `IVP_TRAP_BASE + {16'h0000, n, 1'b0} : `IVP_IRQ_BASE + {16'h0000, n, 1'b0};
      vecAddr = alt ? a + `IVP_ALT_OFFSET : a;
   endfunction

   // Bus state.
   logic dpWrite_q, dpWrite_d, dpValid_q, dpValid_d;
   logic [7:0] dpAddr_q, dpAddr_d;
   logic [31:0] hrdata_d;
   // Control state.
   logic altSel_q, altSel_d;
   logic [6:0] prioSel_q, prioSel_d;
   logic [NUM_IRQ-1:0] flag_q, flag_d, evt;
   logic [`IVP_NUM_TRAPS-1:0] trap_q, trap_d;
   ivp_block_cnt_t blockCnt_q, blockCnt_d;
   logic vecValid_d, vecIsTrap_d;
   ivp_vec_num_t vecNum_d;
   ivp_vec_addr_t vecAddr_d;
   // Priority store access.
   logic memWr;
   logic [6:0] memWrAddr;
   ivp_prio_t memWrData, memRd;
   logic [3*NUM_IRQ-1:0] prioFlat;
   logic addrPhase;

   ivp_prio_mem #(.DEPTH(NUM_IRQ)) prioMem (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wrEn(memWr),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdAddr(prioSel_q),
      .rdData_q(memRd),
      .prioFlat(prioFlat)
   );

   assign addrPhase = hsel && htrans[1] && hready;

   // Event routing and flag update.
   always_comb begin
      evt = irqEvent;
      evt[`IVP_IRQ_I2CB_TGT] = irqEvent[`IVP_IRQ_I2CB_TGT] | i2cBTargetEvent;
      evt[`IVP_IRQ_I2CB_CTL] = irqEvent[`IVP_IRQ_I2CB_CTL] | i2cBControllerEvent;
      evt[`IVP_IRQ_EXT3] = irqEvent[`IVP_IRQ_EXT3] | extPinIrq3;
      evt[`IVP_IRQ_EXT4] = irqEvent[`IVP_IRQ_EXT4] | extPinIrq4;
      evt[`IVP_IRQ_CANB_RX] = irqEvent[`IVP_IRQ_CANB_RX] | canBRxReady;
      evt[`IVP_IRQ_CANB_EVT] = irqEvent[`IVP_IRQ_CANB_EVT] | canBEvent;
      evt[`IVP_IRQ_CODEC_ERR] = irqEvent[`IVP_IRQ_CODEC_ERR] | codecIfError;
      evt[`IVP_IRQ_CODEC_DONE] = irqEvent[`IVP_IRQ_CODEC_DONE] | codecIfDone;
      evt[`IVP_IRQ_XFER5] = irqEvent[`IVP_IRQ_XFER5] | xferChan5Done;
      evt[`IVP_IRQ_XFER6] = irqEvent[`IVP_IRQ_XFER6] | xferChan6Done;
      evt[`IVP_IRQ_XFER7] = irqEvent[`IVP_IRQ_XFER7] | xferChan7Done;
      evt[`IVP_IRQ_CANA_TX] = irqEvent[`IVP_IRQ_CANA_TX] | canATxRequest;
      evt[`IVP_IRQ_CANB_TX] = irqEvent[`IVP_IRQ_CANB_TX] | canBTxRequest;

      flag_d = flag_q;
      trap_d = trap_q;
      if (cpuAck && vecValid_q) begin
         if (vecIsTrap_q) begin
            trap_d[vecNum_q[2:0]] = 1'b0;
         end else begin
            flag_d[vecNum_q - `IVP_IRQ_VEC_OFFSET] = 1'b0;
         end
      end
      // software writes to flag status register 2
      if (dpValid_q && dpWrite_q && (dpAddr_q == `IVP_REG_FLAG_STATUS_2)) begin
         flag_d[`IVP_FS2_FIRST_IRQ +: 16] = hwdata[15:0];
      end
      // a new request sets its flag, and wins over any clear
      flag_d = flag_d | evt;
      for (int t = 0; t < `IVP_NUM_TRAPS; t++) begin
         if (trapEvent[t] && trapLive(t)) begin
            trap_d[t] = 1'b1;
         end
      end
   end

   // Temporary block counter and winner selection.
   always_comb begin
      int best;
      ivp_prio_t bestPrio, p;
      int t;
      best = 0;
      bestPrio = `IVP_PRIO_OFF;
      p = `IVP_PRIO_OFF;
      t = `IVP_NUM_TRAPS;
      blockCnt_d = blockCnt_q;
      if (blockStart) begin
         blockCnt_d = blockCount;
      end else if (instrRetire && (blockCnt_q != '0)) begin
         blockCnt_d = blockCnt_q - 1'b1;
      end
      // strictly greater keeps the lowest number on ties
      for (int i = 0; i < NUM_IRQ; i++) begin
         p = prioFlat[3*i +: 3];
         if (flag_q[i] && slotLive(i) && (p != `IVP_PRIO_OFF) && (p > cpuPriority) &&
             ((blockCnt_q == '0) || (p == `IVP_PRIO_TOP)) && (p > bestPrio)) begin
            best = i;
            bestPrio = p;
         end
      end
      for (int i = `IVP_NUM_TRAPS - 1; i >= 0; i--) begin
         if (trap_q[i]) begin
            t = i;
         end
      end
      if (t < `IVP_NUM_TRAPS) begin
         vecValid_d = 1'b1;
         vecIsTrap_d = 1'b1;
         vecNum_d = 7'(t);
         vecAddr_d = vecAddr(1'b1, 7'(t), altSel_q);
      end else if (bestPrio != `IVP_PRIO_OFF) begin
         vecValid_d = 1'b1;
         vecIsTrap_d = 1'b0;
         // vector number is request plus eight
         vecNum_d = 7'(best) + `IVP_IRQ_VEC_OFFSET;
         vecAddr_d = vecAddr(1'b0, 7'(best), altSel_q);
      end else begin
         vecValid_d = 1'b0;
         vecIsTrap_d = 1'b0;
         vecNum_d = '0;
         vecAddr_d = '0;
      end
      // A vector taken this cycle is withdrawn until the flags settle.
      if (cpuAck && vecValid_q) begin
         vecValid_d = 1'b0;
      end
   end

   // Register bus: zero wait states, read data captured in the address phase.
   always_comb begin
      logic [7:0] a;
      a = haddr[7:0];
      dpValid_d = addrPhase;
      dpWrite_d = addrPhase && hwrite;
      dpAddr_d = addrPhase ? a : dpAddr_q;
      altSel_d = altSel_q;
      prioSel_d = prioSel_q;
      memWr = 1'b0;
      memWrAddr = prioSel_q;
      memWrData = hwdata[2:0];
      hrdata_d = hrdata_q;
      if (dpValid_q && dpWrite_q) begin
         if (dpAddr_q == `IVP_REG_CTRL) begin
            altSel_d = hwdata[`IVP_CTRL_ALT_BIT];
         end else if (dpAddr_q == `IVP_REG_PRIO_SEL) begin
            prioSel_d = hwdata[6:0];
         end else if (dpAddr_q == `IVP_REG_PRIO_DATA) begin
            memWr = 1'b1;
         end
      end
      // Register 3 fields go through the store one at a time; the three
      // writes cannot share a port, so the slot select picks the field.
      if (dpValid_q && dpWrite_q && (dpAddr_q == `IVP_REG_PRIO_CTRL_3)) begin
         memWr = 1'b1;
         if (prioSel_q == 7'(`IVP_PC3_XFER1_IRQ)) begin
            memWrData = hwdata[`IVP_PC3_XFER1_LSB +: 3];
         end else if (prioSel_q == 7'(`IVP_PC3_CONV_DONE_IRQ)) begin
            memWrData = hwdata[`IVP_PC3_CONV_DONE_LSB +: 3];
         end else if (prioSel_q == 7'(`IVP_PC3_UART_A_TX_IRQ)) begin
            memWrData = hwdata[`IVP_PC3_UART_A_TX_LSB +: 3];
         end else begin
            memWr = 1'b0;
         end
      end
      if (addrPhase && !hwrite) begin
         hrdata_d = 32'h00000000;
         if (a == `IVP_REG_CTRL) begin
            hrdata_d[`IVP_CTRL_ALT_BIT] = altSel_q;
         end else if (a == `IVP_REG_FLAG_STATUS_2) begin
            hrdata_d[15:0] = flag_q[`IVP_FS2_FIRST_IRQ +: 16];
         end else if (a == `IVP_REG_PRIO_CTRL_3) begin
            hrdata_d[`IVP_PC3_XFER1_LSB +: 3] = prioFlat[3*`IVP_PC3_XFER1_IRQ +: 3];
            hrdata_d[`IVP_PC3_CONV_DONE_LSB +: 3] = prioFlat[3*`IVP_PC3_CONV_DONE_IRQ +: 3];
            hrdata_d[`IVP_PC3_UART_A_TX_LSB +: 3] = prioFlat[3*`IVP_PC3_UART_A_TX_IRQ +: 3];
         end else if (a == `IVP_REG_PRIO_SEL) begin
            hrdata_d[6:0] = prioSel_q;
         end else if (a == `IVP_REG_PRIO_DATA) begin
            hrdata_d[2:0] = memRd;
         end else if (a == `IVP_REG_STATUS) begin
            hrdata_d[0] = vecValid_q;
            hrdata_d[1] = vecIsTrap_q;
            hrdata_d[14:8] = vecNum_q;
            hrdata_d[16 +: `IVP_BLOCK_CNT_W] = blockCnt_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dpValid_q <= 1'b0;
         dpWrite_q <= 1'b0;
         dpAddr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
         altSel_q <= 1'b0;
         prioSel_q <= 7'h00;
         flag_q <= '0;
         trap_q <= '0;
         blockCnt_q <= '0;
         blockActive_q <= 1'b0;
         vecValid_q <= 1'b0;
         vecIsTrap_q <= 1'b0;
         vecNum_q <= 7'h00;
         vecAddr_q <= 24'h000000;
      end else if (ce) begin
         dpValid_q <= dpValid_d;
         dpWrite_q <= dpWrite_d;
         dpAddr_q <= dpAddr_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
         altSel_q <= altSel_d;
         prioSel_q <= prioSel_d;
         flag_q <= flag_d;
         trap_q <= trap_d;
         blockCnt_q <= blockCnt_d;
         blockActive_q <= (blockCnt_d != '0);
         vecValid_q <= vecValid_d;
         vecIsTrap_q <= vecIsTrap_d;
         vecNum_q <= vecNum_d;
         vecAddr_q <= vecAddr_d;
      end
   end
endmodule // ivp_ctrl

//--- ivp_chk.sv
/* Port checker for the interrupt vector controller.
   Bound to every ivp_ctrl instance; sees only its ports. */
`timescale 1ns/1ns
module ivp_chk #(
   parameter int NUM_IRQ = 118
) (
   input wire logic clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic ce, // Clock enable.
   input wire logic [7:0] trapEvent, // Trap pulses.
   input wire logic extPinIrq3, // Pin 3 event.
   input wire ivp_pkg::ivp_prio_t cpuPriority, // CPU level.
   input wire logic blockStart, // Block load.
   input wire ivp_pkg::ivp_block_cnt_t blockCount, // Block length.
   input wire logic instrRetire, // Retire pulse.
   input wire logic cpuAck, // Vector taken.
   input wire logic vecValid_q, // Vector presented.
   input wire logic vecIsTrap_q, // Vector is a trap.
   input wire ivp_pkg::ivp_vec_num_t vecNum_q, // Vector number.
   input wire ivp_pkg::ivp_vec_addr_t vecAddr_q, // Vector address.
   input wire logic blockActive_q // Block in force.
);
   import ivp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_trap1;
      ce && trapEvent[1] && !cpuAck ##1 ce && !cpuAck;
   endsequence
   sequence s_block1;
      ce && blockStart && blockCount == 14'h0001 ##1 ce && instrRetire && !blockStart;
   endsequence
   sequence s_pin3;
      ce && extPinIrq3 && !vecValid_q && !blockActive_q && cpuPriority == 3'h0
         && trapEvent == 8'h00 ##1 ce && !cpuAck;
   endsequence
   rsv_trap_a: assert property (vecValid_q && vecIsTrap_q |->
      vecNum_q inside {[7'h01:7'h05]}) else $error("reserved trap presented");
   vec_addr_a: assert property (vecValid_q |-> vecAddr_q[23:9] == 15'h0
      && vecAddr_q[7:0] == {vecNum_q, 1'b0} + 8'h04) else $error("vector address wrong");
   rsv_irq_a: assert property (vecValid_q && !vecIsTrap_q |->
      vecNum_q inside {[7'h08:7'h4f]} && !(vecNum_q inside {7'h41, 7'h42, 7'h46, 7'h47,
      7'h48, 7'h4b})) else $error("reserved request presented");
   ack_drop_a: assert property (ce && vecValid_q && cpuAck |=> !vecValid_q)
      else $error("vector kept after take");
   trap_win_a: assert property (s_trap1 |=> vecValid_q && vecIsTrap_q
      && vecNum_q == 7'h01) else $error("trap not presented");
   block_load_a: assert property (ce && blockStart && blockCount != 14'h0
      |=> blockActive_q) else $error("block not started");
   block_end_a: assert property (s_block1 |=> !blockActive_q)
      else $error("block not ended");
   pin3_vec_a: assert property (s_pin3 |=> vecValid_q && vecNum_q == 7'h3d)
      else $error("pin 3 request not presented");
endmodule // ivp_chk

bind ivp_ctrl ivp_chk #(.NUM_IRQ(NUM_IRQ)) i_ivp_chk (.clk(clk), .rst(rst), .ce(ce),
   .trapEvent(trapEvent), .extPinIrq3(extPinIrq3), .cpuPriority(cpuPriority),
   .blockStart(blockStart), .blockCount(blockCount), .instrRetire(instrRetire),
   .cpuAck(cpuAck), .vecValid_q(vecValid_q), .vecIsTrap_q(vecIsTrap_q),
   .vecNum_q(vecNum_q), .vecAddr_q(vecAddr_q), .blockActive_q(blockActive_q));

//--- ivp_cpu_model.sv
/* CPU core model: takes presented vectors and retires instructions.
   Assumes the controller's registered vector port and its take pulse. */
`timescale 1ns/1ns
module ivp_cpu_model (
   input wire logic clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic ackEn, // Allow taking vectors.
   input wire logic retireEn, // Retire one instruction a cycle.
   input wire logic vecValid_q, // Vector presented.
   input wire ivp_pkg::ivp_vec_num_t vecNum_q, // Vector number.
   input wire ivp_pkg::ivp_vec_addr_t vecAddr_q, // Vector address.
   output logic cpuAck, // Take pulse.
   output logic instrRetire, // Retire pulse.
   output ivp_pkg::ivp_vec_num_t takenNum, // Last number taken.
   output ivp_pkg::ivp_vec_addr_t takenAddr, // Last address taken.
   output int takenCnt // Vectors taken.
);
   import ivp_pkg::*;
   logic [1:0] waitCnt;
   // The take is deferred, as a core stacking its context would, so winners settle first.
   always_ff @(posedge clk) begin
      if (rst) begin
         cpuAck <= 1'b0;
         instrRetire <= 1'b0;
         takenNum <= 7'h0;
         takenAddr <= 24'h0;
         takenCnt <= 0;
         waitCnt <= 2'h0;
      end else begin
         instrRetire <= retireEn;
         cpuAck <= 1'b0;
         if (cpuAck) begin
            takenNum <= vecNum_q;
            takenAddr <= vecAddr_q;
            takenCnt <= takenCnt + 1;
            waitCnt <= 2'h0;
         end else if (vecValid_q && ackEn) begin
            if (waitCnt == 2'h2) cpuAck <= 1'b1;
            else waitCnt <= waitCnt + 2'h1;
         end else waitCnt <= 2'h0;
      end
   end
endmodule // ivp_cpu_model

//--- ivp_ctrl_tb.sv
/* Self-checking bench for the interrupt vector controller.
   Assumes the checker is bound and the CPU model stands at the vector port. */
`timescale 1ns/1ns
module ivp_ctrl_tb;
   import ivp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [117:0] irqEvent = 118'h0;
   logic [7:0] trapEvent = 8'h0;
   logic [12:0] src = 13'h0;
   ivp_prio_t cpuPriority = 3'h0;
   logic blockStart = 1'b0;
   ivp_block_cnt_t blockCount = 14'h0;
   logic ackEn = 1'b0;
   logic retireEn = 1'b0;
   logic hreadyout_q, hresp_q, cpuAck, instrRetire, vecValid_q, vecIsTrap_q, blockActive_q;
   logic [31:0] hrdata_q, rd;
   ivp_vec_num_t vecNum_q, takenNum;
   ivp_vec_addr_t vecAddr_q, takenAddr;
   int takenCnt, seen = 0, errors = 0, compares = 0;
   logic [6:0] route [13] = '{7'h31, 7'h32, 7'h35, 7'h36, 7'h37, 7'h38, 7'h3b, 7'h3c,
      7'h3d, 7'h44, 7'h45, 7'h46, 7'h47};
   always #50 clk = ~clk;
   ivp_ctrl i_ivp_ctrl (.clk(clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout_q), .hreadyout_q(hreadyout_q), .hrdata_q(hrdata_q),
      .hresp_q(hresp_q), .irqEvent(irqEvent), .trapEvent(trapEvent),
      .i2cBTargetEvent(src[0]), .i2cBControllerEvent(src[1]), .extPinIrq3(src[2]),
      .extPinIrq4(src[3]), .canBRxReady(src[4]), .canBEvent(src[5]),
      .codecIfError(src[6]), .codecIfDone(src[7]), .xferChan5Done(src[8]),
      .xferChan6Done(src[9]), .xferChan7Done(src[10]), .canATxRequest(src[11]),
      .canBTxRequest(src[12]), .cpuPriority(cpuPriority), .blockStart(blockStart),
      .blockCount(blockCount), .instrRetire(instrRetire), .cpuAck(cpuAck),
      .vecValid_q(vecValid_q), .vecIsTrap_q(vecIsTrap_q), .vecNum_q(vecNum_q),
      .vecAddr_q(vecAddr_q), .blockActive_q(blockActive_q));
   ivp_cpu_model i_ivp_cpu_model (.clk(clk), .rst(rst), .ackEn(ackEn),
      .retireEn(retireEn), .vecValid_q(vecValid_q), .vecNum_q(vecNum_q),
      .vecAddr_q(vecAddr_q), .cpuAck(cpuAck), .instrRetire(instrRetire),
      .takenNum(takenNum), .takenAddr(takenAddr), .takenCnt(takenCnt));
   task close_out;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task addr_ph(input logic [7:0] a, input logic w);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      addr_ph(a, 1'b1);
      hwdata <= d;
      do @(posedge clk); while (hreadyout_q !== 1'b1);
   endtask
   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      addr_ph(a, 1'b0);
      do @(posedge clk); while (hreadyout_q !== 1'b1);
      d = hrdata_q;
   endtask
   task pulse_irq(input int n);
      @(posedge clk) irqEvent[n] <= 1'b1;
      @(posedge clk) irqEvent[n] <= 1'b0;
   endtask
   task pulse_trap(input int n);
      @(posedge clk) trapEvent[n] <= 1'b1;
      @(posedge clk) trapEvent[n] <= 1'b0;
   endtask
   task take(input logic [6:0] n, input logic [23:0] a);
      int k;
      k = 0;
      while (takenCnt == seen && k < 40) begin
         @(posedge clk);
         k++;
      end
      seen = takenCnt;
      check("vector taken", {31'h0, k < 40}, 32'h1);
      check("vector number", {25'h0, takenNum}, {25'h0, n});
      check("vector address", {8'h0, takenAddr}, {8'h0, a});
   endtask
   task quiet;
      repeat (6) @(posedge clk);
      check("nothing taken", takenCnt, seen);
      check("no vector", {31'h0, vecValid_q}, 32'h0);
   endtask
   task t_regs;
      rd_reg(8'h08, rd);
      check("prio reset", rd, 32'h444);
      rd_reg(8'h04, rd);
      check("flags reset", rd, 32'h0);
      rd_reg(8'h40, rd);
      check("unmapped", rd, 32'h0);
      wr(8'h0c, 32'hd);
      wr(8'h08, 32'h777);
      rd_reg(8'h08, rd);
      check("prio field", rd, 32'h744);
      wr(8'h08, 32'h0);
      rd_reg(8'h08, rd);
      check("prio off", rd, 32'h044);
      wr(8'h10, 32'h4);
      rd_reg(8'h10, rd);
      check("prio data", rd, 32'h4);
      check("okay resp", {31'h0, hresp_q}, 32'h0);
   endtask
   task t_flags;
      cpuPriority <= 3'h7;
      for (int i = 32; i < 35; i++) pulse_irq(i);
      rd_reg(8'h04, rd);
      check("flags set", rd, 32'h7);
      wr(8'h04, 32'h0);
      rd_reg(8'h04, rd);
      check("flags clear", rd, 32'h0);
      cpuPriority <= 3'h0;
   endtask
   task t_route;
      ackEn <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         @(posedge clk) src[i] <= 1'b1;
         @(posedge clk) src[i] <= 1'b0;
         take(route[i] + 7'h08, 24'h14 + {route[i], 1'b0});
      end
      pulse_irq(46);
      take(7'h36, 24'h70);
      wr(8'h00, 32'h1);
      pulse_irq(46);
      take(7'h36, 24'h170);
      pulse_trap(5);
      take(7'h05, 24'h10e);
      wr(8'h00, 32'h0);
   endtask
   task t_traps;
      for (int n = 0; n < 8; n++) begin
         pulse_trap(n);
         if (n >= 1 && n <= 5) take(n[6:0], 24'h4 + 24'(2 * n));
         else quiet();
      end
   endtask
   task t_prio;
      wr(8'h0c, 32'hd);
      wr(8'h10, 32'h7);
      wr(8'h0c, 32'hb);
      wr(8'h10, 32'h0);
      rd_reg(8'h08, rd);
      check("prio mix", rd, 32'h740);
      @(posedge clk);
      irqEvent[13:11] <= 3'h7;
      irqEvent[72] <= 1'b1;
      trapEvent[3] <= 1'b1;
      @(posedge clk);
      irqEvent <= 118'h0;
      trapEvent <= 8'h0;
      take(7'h03, 24'h0a);
      take(7'h15, 24'h2e);
      take(7'h14, 24'h2c);
      quiet();
      wr(8'h10, 32'h4);
      take(7'h13, 24'h2a);
   endtask
   task t_block;
      @(posedge clk);
      blockStart <= 1'b1;
      blockCount <= 14'h5;
      @(posedge clk) blockStart <= 1'b0;
      pulse_irq(46);
      quiet();
      check("block on", {31'h0, blockActive_q}, 32'h1);
      rd_reg(8'h14, rd);
      check("status count", rd, 32'h50000);
      wr(8'h0c, 32'hd);
      wr(8'h10, 32'h7);
      pulse_irq(13);
      take(7'h15, 24'h2e);
      retireEn <= 1'b1;
      take(7'h36, 24'h70);
      check("block off", {31'h0, blockActive_q}, 32'h0);
      @(posedge clk);
      blockStart <= 1'b1;
      blockCount <= 14'h1;
      @(posedge clk) blockStart <= 1'b0;
      repeat (3) @(posedge clk);
      check("short block", {31'h0, blockActive_q}, 32'h0);
      retireEn <= 1'b0;
      wr(8'h10, 32'h4);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      while (hreadyout_q !== 1'b1) @(posedge clk);
      t_regs();
      t_flags();
      t_route();
      t_traps();
      t_prio();
      t_block();
      close_out();
   end
   // The tests need well under 2000 cycles; ten times that means a hang.
   initial begin
      #2000000;
      errors++;
      close_out();
   end
endmodule // ivp_ctrl_tb
